// file: bfrs_top.sv
// Behaviour
// RULE1: high side on at each period start
// RULE2: rest of period low side on
// RULE3: shutdown holds both switches off
// RULE4: one regulator, aux above 4.7V else main
// RULE5: both regulators off below 3.8V, on above 4.2V
// RULE6: no resistor gives 490kHz default
// RULE7: switch to external clock after 16 edges
// RULE8: peak limit ends on-time immediately
// RULE9: runaway limit enters hiccup at once
// RULE10: feedback fault after soft-start enters hiccup
// RULE11: hiccup suspends switching 32768 cycles
// RULE12: hiccup end restarts soft-start
// RULE13: low feedback during soft-start halves frequency
// RULE14: reset released 1024 cycles after 95%
// RULE15: below 92% reset low, count dropped
// RULE16: reset low during thermal shutdown
// RULE17: over-temp shuts down, resumes after cooling
// RULE18: prebias keeps switches off until pwm
// RULE19: counters count periods, cleared when disabled
// RULE20: soft-start done bit arms feedback fault
`timescale 1ns/1ns
`default_nettype none
module bfrs_top
	import bfrs_pkg::*;
(
	// clock and reset
	input  wire logic                clk,
	input  wire logic                sys_rst,
	// analog comparator inputs
	input  wire bfrs_sense_s         sense,
	// programmed period from timing resistor
	input  wire logic [PERIOD_W-1:0] rt_period,
	// switch drivers, regulators and reset pin
	output bfrs_drive_s              drive,
	// status
	output logic                     in_hiccup,
	output logic                     switch_node_hiz
);
	// controller state
	typedef struct packed
	{
		bfrs_state_e      state;     // operating state
		logic             hs;        // high-side switch
		logic             ls;        // low-side switch
		logic             half_skip; // alternate period skip
		logic [HIC_W-1:0] hic_cnt;   // hiccup period counter
		logic [9:0]       rst_cnt;   // reset release counter
		logic             rst_rel;   // reset pin released
		logic             aux_sel;   // aux regulator chosen
		logic             ldo_on;    // regulators allowed
	} bfrs_ctl_s;

	bfrs_ctl_s   st_reg;
	bfrs_ctl_s   st_next;
	logic        period_start;      // one pulse per switching period
	logic        osc_run;           // oscillator runs while enabled and regulators allowed
	logic [PERIOD_W-1:0] prog_period; // chosen internal period

	// true when switching is permitted
	function automatic logic may_switch(input bfrs_state_e s);
		may_switch = (s == BFRS_RUN);
	endfunction

	// default period when no resistor present
	assign prog_period = sense.rt_present ? rt_period : PERIOD_W'(DEF_PERIOD_CYC); // RULE6
	assign osc_run = sense.enable_lockout_input & st_reg.ldo_on;

	// oscillator with sync changeover
	bfrs_osc u_osc
	(
		.clk          (clk),
		.sys_rst      (sys_rst),
		.run          (osc_run),
		.prog_period  (prog_period),
		.sync_level   (sense.freq_set_sync_input),
		.period_start (period_start)
	);

	// next-state logic
	always_comb
	begin
		logic shutdown;
		logic hs_end;
		shutdown = 1'b0;
		hs_end = 1'b0;
		st_next = st_reg;

		// regulator supervision with hysteresis
		if (sense.vcc_below_low)
			st_next.ldo_on = 1'b0; // RULE5
		else if (sense.vcc_above_high)
			st_next.ldo_on = 1'b1; // RULE5
		st_next.aux_sel = sense.aux_supply_ok; // RULE4

		shutdown = !sense.enable_lockout_input || !st_reg.ldo_on;

		// operating state sequence
		unique case (st_reg.state)
			BFRS_OFF:
			begin
				// waiting for enable
				if (!shutdown)
					st_next.state = BFRS_PREBIAS;
			end
			BFRS_PREBIAS:
			begin
				// hold off until modulator asks for a pulse
				if (!sense.pwm_trip)
					st_next.state = BFRS_RUN; // RULE18
			end
			BFRS_RUN:
			begin
				// overcurrent and feedback faults
				if (sense.runaway_limit)
					st_next.state = BFRS_HICCUP; // RULE9
				else if (sense.soft_start_done && !sense.fb_above_fault)
					st_next.state = BFRS_HICCUP; // RULE10 RULE20
			end
			BFRS_HICCUP:
			begin
				// count suspended periods
				if (period_start)
				begin
					if (st_reg.hic_cnt == HIC_W'(HICCUP_PERIODS - 1))
						st_next.state = BFRS_PREBIAS; // RULE12
					st_next.hic_cnt = st_reg.hic_cnt + 1'b1; // RULE11 RULE19
				end
			end
			BFRS_THERMAL:
			begin
				// wait for cooling
				if (sense.temp_cooled)
					st_next.state = BFRS_OFF; // RULE17
			end
			default:
				st_next.state = BFRS_OFF;
		endcase

		if (st_next.state != BFRS_HICCUP)
			st_next.hic_cnt = '0;

		// thermal overrides everything, shutdown everything but thermal
		if (sense.over_temp)
			st_next.state = BFRS_THERMAL; // RULE17
		else if (shutdown && st_reg.state != BFRS_THERMAL)
			st_next.state = BFRS_OFF;

		// switch sequencing per period
		hs_end = sense.pwm_trip || sense.max_duty || sense.peak_limit;
		if (!may_switch(st_next.state))
		begin
			st_next.hs = 1'b0; // RULE3
			st_next.ls = 1'b0; // RULE3
			st_next.half_skip = 1'b0;
		end
		else if (period_start)
		begin
			// low feedback in soft-start skips every other period
			st_next.half_skip = !sense.soft_start_done && !sense.fb_above_fault && !st_reg.half_skip; // RULE13
			st_next.hs = !st_next.half_skip; // RULE1
			st_next.ls = st_next.half_skip;
		end
		else if (st_reg.hs && hs_end)
		begin
			st_next.hs = 1'b0; // RULE8
			st_next.ls = 1'b1; // RULE2
		end

		// reset pin qualification
		if (st_next.state == BFRS_THERMAL || shutdown)
		begin
			st_next.rst_rel = 1'b0; // RULE16
			st_next.rst_cnt = '0; // RULE19
		end
		else if (sense.out_below_ok_fall)
		begin
			st_next.rst_rel = 1'b0; // RULE15
			st_next.rst_cnt = '0; // RULE15
		end
		else if (sense.out_above_ok_rise && !st_reg.rst_rel && period_start)
		begin
			if (st_reg.rst_cnt == RST_DLY_PERIODS)
				st_next.rst_rel = 1'b1; // RULE14
			else
				st_next.rst_cnt = st_reg.rst_cnt + 10'h001; // RULE14
		end
		else if (!sense.out_above_ok_rise && !st_reg.rst_rel)
			st_next.rst_cnt = '0;
	end

	// state register
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			st_reg <= '0;
			st_reg.state <= BFRS_OFF;
		end
		else
			st_reg <= st_next;
	end

	// outputs; immediate peak cut on high side
	assign drive.high_side_on   = st_reg.hs & ~sense.peak_limit & ~sense.runaway_limit; // RULE8
	assign drive.low_side_on    = st_reg.ls & ~st_reg.hs;
	assign drive.aux_ldo_en     = st_reg.ldo_on & st_reg.aux_sel; // RULE4
	assign drive.main_ldo_en    = st_reg.ldo_on & ~st_reg.aux_sel; // RULE4
	assign drive.reset_out      = 1'b0;
	assign drive.reset_out_oe_n = st_reg.rst_rel;
	assign in_hiccup            = (st_reg.state == BFRS_HICCUP);
	assign switch_node_hiz      = ~st_reg.hs & ~st_reg.ls;
endmodule
`default_nettype wire

// file: bfrs_pkg.sv
package bfrs_pkg;
	// internal oscillator timing at 100 MHz system clock
	localparam int unsigned CLK_FREQ_HZ     = 100_000_000;
	localparam int unsigned DEF_FSW_HZ      = 490_000;
	// period count for default frequency, rounded down
	localparam int unsigned DEF_PERIOD_CYC  = CLK_FREQ_HZ / DEF_FSW_HZ;
	localparam int unsigned PERIOD_W        = 16;
	// external edges needed before changing over to sync clock
	localparam logic [4:0]  SYNC_EDGES      = 5'h10;
	// hiccup and reset-release counts in switching periods
	localparam int unsigned HICCUP_PERIODS  = 32768;
	localparam logic [9:0]  RST_DLY_PERIODS = 10'h3FF;
	localparam int unsigned HIC_W           = 16;

	// controller states
	typedef enum logic [2:0]
	{
		BFRS_OFF     = 3'b000,
		BFRS_PREBIAS = 3'b001,
		BFRS_RUN     = 3'b010,
		BFRS_HICCUP  = 3'b011,
		BFRS_THERMAL = 3'b100
	} bfrs_state_e;

	// analog comparator inputs
	typedef struct packed
	{
		logic enable_lockout_input; // enable above lockout threshold
		logic aux_supply_ok;        // aux supply above 4.7V
		logic vcc_below_low;        // rail below 3.8V
		logic vcc_above_high;       // rail above 4.2V
		logic rt_present;           // timing resistor detected
		logic freq_set_sync_input;  // sync pulse level
		logic pwm_trip;             // modulation comparator reached duty
		logic max_duty;             // maximum duty reached
		logic peak_limit;           // current above 1.75A
		logic runaway_limit;        // current at 2A
		logic fb_above_fault;       // feedback above 0.58V
		logic soft_start_done;      // reference ramp finished
		logic out_above_ok_rise;    // output above 95%
		logic out_below_ok_fall;    // output below 92%
		logic over_temp;            // temperature above trip
		logic temp_cooled;          // temperature down by hysteresis
	} bfrs_sense_s;

	// driver outputs
	typedef struct packed
	{
		logic high_side_on;
		logic low_side_on;
		logic main_ldo_en;
		logic aux_ldo_en;
		logic reset_out;     // always low when driving
		logic reset_out_oe_n;
	} bfrs_drive_s;
endpackage

// file: bfrs_osc.sv
`timescale 1ns/1ns
`default_nettype none
module bfrs_osc
	import bfrs_pkg::*;
(
	// clock and reset
	input  wire logic                clk,
	input  wire logic                sys_rst,
	// control
	input  wire logic                run,
	input  wire logic [PERIOD_W-1:0] prog_period,
	input  wire logic                sync_level,
	// period start pulse
	output logic                     period_start
);
	// oscillator state
	typedef struct packed
	{
		logic [PERIOD_W-1:0] cnt;      // internal period counter
		logic                sync_q;   // previous sync level
		logic [4:0]          edges;    // sync rising edges seen
		logic                locked;   // following external clock
		logic                pulse;    // registered period start
	} bfrs_osc_s;

	bfrs_osc_s st_reg;
	bfrs_osc_s st_next;

	// next-state logic
	always_comb
	begin
		logic sync_rise;
		sync_rise = 1'b0;
		st_next = st_reg;
		st_next.pulse = 1'b0;
		sync_rise = sync_level & ~st_reg.sync_q;
		st_next.sync_q = sync_level;
		if (!run)
		begin
			// idle: forget lock and period phase
			st_next.cnt = '0;
			st_next.edges = '0;
			st_next.locked = 1'b0;
		end
		else
		begin
			// count external edges until lock
			if (sync_rise && !st_reg.locked)
			begin
				st_next.edges = st_reg.edges + 5'h01;
				if (st_reg.edges + 5'h01 == SYNC_EDGES)
					st_next.locked = 1'b1; // RULE7
			end
			if (st_reg.locked)
			begin
				// external clock sets period
				st_next.pulse = sync_rise; // RULE7
			end
			else if (st_reg.cnt + 1'b1 >= prog_period)
			begin
				// programmed period elapsed
				st_next.cnt = '0;
				st_next.pulse = 1'b1;
			end
			else
				st_next.cnt = st_reg.cnt + 1'b1;
		end
	end

	// state register
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign period_start = st_reg.pulse;
endmodule
`default_nettype wire

// file: bfrs_analog.sv
`timescale 1ns/1ns
`default_nettype none
module bfrs_analog
	import bfrs_pkg::*;
(
	// clock
	input  wire logic        clk,
	// switch drivers and reset pin driver
	input  wire bfrs_drive_s drive,
	// modulator trip and board reset wire
	output logic             pwm_trip,
	output logic             reset_pin
);
	logic [3:0] on_cnt = 4'h0; // cycles the high side has been on

	// on-time counter, restarts whenever the high side is off
	always_ff @(posedge clk)
	begin
		on_cnt <= drive.high_side_on ? on_cnt + 4'h1 : 4'h0;
	end

	// modulator trips after two cycles of on-time, low again one cycle after the high side turns off
	assign pwm_trip = (on_cnt >= 4'h2);
	// pull-up wins while the pin is released
	assign reset_pin = drive.reset_out_oe_n ? 1'b1 : drive.reset_out;
endmodule
`default_nettype wire

// file: bfrs_top_checker.sv
`timescale 1ns/1ns
`default_nettype none
module bfrs_top_checker
	import bfrs_pkg::*;
(
	// clock and reset
	input  wire logic                clk,
	input  wire logic                sys_rst,
	// watched ports
	input  wire bfrs_sense_s         sense,
	input  wire logic [PERIOD_W-1:0] rt_period,
	input  wire bfrs_drive_s         drive,
	input  wire logic                in_hiccup,
	input  wire logic                switch_node_hiz
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	property p_hiz;
		switch_node_hiz |-> !drive.high_side_on && !drive.low_side_on;
	endproperty
	a_hiz: assert property (p_hiz) else $error("switch on while node idle");
	property p_overlap;
		!(drive.high_side_on && drive.low_side_on);
	endproperty
	a_overlap: assert property (p_overlap) else $error("both switches on");
	property p_one_ldo;
		!(drive.main_ldo_en && drive.aux_ldo_en);
	endproperty
	a_one_ldo: assert property (p_one_ldo) else $error("two regulators on");
	property p_ldo_sel;
		drive.main_ldo_en || drive.aux_ldo_en |-> drive.aux_ldo_en == $past(sense.aux_supply_ok);
	endproperty
	a_ldo_sel: assert property (p_ldo_sel) else $error("wrong regulator chosen");
	property p_supply_lockout;
		sense.vcc_below_low |=> !drive.main_ldo_en && !drive.aux_ldo_en;
	endproperty
	a_supply_lockout: assert property (p_supply_lockout) else $error("regulator on under lockout");
	property p_peak;
		sense.peak_limit |-> !drive.high_side_on;
	endproperty
	a_peak: assert property (p_peak) else $error("high side on past peak");
	property p_runaway;
		sense.runaway_limit && !switch_node_hiz && !sense.over_temp |=> in_hiccup;
	endproperty
	a_runaway: assert property (p_runaway) else $error("no hiccup on runaway");
	property p_hic_quiet;
		in_hiccup |-> !drive.high_side_on && !drive.low_side_on;
	endproperty
	a_hic_quiet: assert property (p_hic_quiet) else $error("switching in hiccup");
	property p_thermal;
		sense.over_temp [*3] |-> !drive.reset_out_oe_n && switch_node_hiz;
	endproperty
	a_thermal: assert property (p_thermal) else $error("reset free in thermal stop");
	property p_drop;
		sense.out_below_ok_fall |=> !drive.reset_out_oe_n;
	endproperty
	a_drop: assert property (p_drop) else $error("reset not pulled on drop");
endmodule
bind bfrs_top bfrs_top_checker i_bfrs_top_checker (.clk(clk), .sys_rst(sys_rst), .sense(sense),
	.rt_period(rt_period), .drive(drive), .in_hiccup(in_hiccup), .switch_node_hiz(switch_node_hiz));
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top
	import bfrs_pkg::*;
();
	logic                clk, sys_rst, in_hiccup, switch_node_hiz, pwm_trip, reset_pin, hs_q, sync_run;
	bfrs_sense_s         sns;   // comparator levels set by the bench
	bfrs_sense_s         sense; // same, with the modulator trip merged
	logic [PERIOD_W-1:0] rt_period;
	bfrs_drive_s         drive;
	int                  miscompares, comparisons, n;

	// merge modulator output into comparator bundle
	always_comb
	begin
		sense = sns;
		sense.pwm_trip = pwm_trip;
	end
	// previous high side level for edge detection
	always @(posedge clk) hs_q <= drive.high_side_on;

	bfrs_top i_bfrs_top (.clk(clk), .sys_rst(sys_rst), .sense(sense), .rt_period(rt_period),
		.drive(drive), .in_hiccup(in_hiccup), .switch_node_hiz(switch_node_hiz));
	bfrs_analog i_bfrs_analog (.clk(clk), .drive(drive), .pwm_trip(pwm_trip), .reset_pin(reset_pin));

	task automatic chk_b(input logic e, input logic g, input string m);
		comparisons++;
		if (g !== e)
		begin
			miscompares++;
			$display("wrong value %0t %s", $time, m);
		end
	endtask
	task automatic chk_n(input int lo, input int hi, input int g, input string m);
		comparisons++;
		if (g < lo || g > hi)
		begin
			miscompares++;
			$display("wrong value %0t %s %0d", $time, m, g);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	// cycles up to the next high side turn-on
	task automatic rise(output int c);
		c = 0;
		do
		begin
			tick(1);
			c++;
		end
		while (!(drive.high_side_on === 1'b1 && hs_q === 1'b0) && c < 5000);
	endtask
	task automatic test_done();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic t_ldo();
		sns.vcc_above_high = 1'b1;
		tick(3);
		chk_b(1'b1, drive.main_ldo_en & ~drive.aux_ldo_en, "main ldo");
		sns.aux_supply_ok = 1'b1;
		tick(2);
		chk_b(1'b1, drive.aux_ldo_en & ~drive.main_ldo_en, "aux ldo");
		sns.vcc_above_high = 1'b0;
		sns.vcc_below_low = 1'b1;
		tick(2);
		chk_b(1'b0, drive.aux_ldo_en | drive.main_ldo_en, "lockout");
		sns.vcc_below_low = 1'b0;
		sns.vcc_above_high = 1'b1;
		tick(2);
	endtask
	task automatic t_run();
		sns.enable_lockout_input = 1'b1;
		rise(n);
		rise(n);
		chk_n(8, 8, n, "period");
		tick(4);
		chk_b(1'b1, drive.low_side_on & ~drive.high_side_on, "off phase");
		rise(n);
		sns.peak_limit = 1'b1;
		#1;
		chk_b(1'b0, drive.high_side_on, "peak cut");
		tick(1);
		sns.peak_limit = 1'b0;
	endtask
	task automatic t_half();
		sns.soft_start_done = 1'b0;
		sns.fb_above_fault = 1'b0;
		rise(n);
		rise(n);
		chk_n(16, 16, n, "half rate");
		sns.fb_above_fault = 1'b1;
		sns.soft_start_done = 1'b1;
	endtask
	task automatic t_sync();
		sync_run = 1'b1;
		tick(150);
		rise(n);
		rise(n);
		chk_n(6, 6, n, "sync period");
		sync_run = 1'b0;
		sns.enable_lockout_input = 1'b0;
		tick(3);
		chk_b(1'b1, switch_node_hiz, "shutdown");
		sns.enable_lockout_input = 1'b1;
	endtask
	task automatic t_fault();
		rise(n);
		sns.fb_above_fault = 1'b0;
		tick(3);
		chk_b(1'b1, in_hiccup, "fb fault");
		sns.fb_above_fault = 1'b1;
		sns.enable_lockout_input = 1'b0;
		tick(3);
		chk_b(1'b0, in_hiccup, "cleared");
		sns.enable_lockout_input = 1'b1;
	endtask
	task automatic t_hic();
		int c;
		rise(n);
		sns.runaway_limit = 1'b1;
		tick(1);
		sns.runaway_limit = 1'b0;
		tick(1);
		chk_b(1'b1, in_hiccup, "runaway");
		rt_period = 16'h0002;
		c = 2;
		while (in_hiccup === 1'b1 && c < 80000)
		begin
			tick(1);
			c++;
		end
		rt_period = 16'h0008;
		chk_n(65500, 65560, c, "hiccup time");
		rise(n);
		chk_n(1, 200, n, "restart");
	endtask
	task automatic t_rst();
		int c;
		sns.out_above_ok_rise = 1'b1;
		c = 0;
		while (reset_pin !== 1'b1 && c < 9000)
		begin
			tick(1);
			c++;
		end
		chk_n(8180, 8210, c, "release delay");
		sns.out_above_ok_rise = 1'b0;
		sns.out_below_ok_fall = 1'b1;
		tick(2);
		chk_b(1'b0, reset_pin, "drop");
		sns.out_below_ok_fall = 1'b0;
		sns.over_temp = 1'b1;
		tick(4);
		chk_b(1'b0, reset_pin, "thermal reset");
		chk_b(1'b1, switch_node_hiz, "thermal stop");
		sns.over_temp = 1'b0;
		sns.temp_cooled = 1'b1;
		rise(n);
		chk_n(1, 300, n, "resume");
	endtask
	task automatic t_def();
		sns.rt_present = 1'b0;
		rise(n);
		rise(n);
		chk_n(DEF_PERIOD_CYC, DEF_PERIOD_CYC, n, "default period");
		sns.rt_present = 1'b1;
	endtask

	// free-running clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// external sync pulses, six cycle period
	always
	begin
		tick(3);
		if (sync_run)
			sns.freq_set_sync_input = ~sns.freq_set_sync_input;
	end
	// hang guard
	initial
	begin
		#1500000;
		miscompares++;
		test_done();
	end
	// main sequence
	initial
	begin
		sys_rst = 1'b1;
		sns = '0;
		sns.rt_present = 1'b1;
		sns.soft_start_done = 1'b1;
		sns.fb_above_fault = 1'b1;
		rt_period = 16'h0008;
		sync_run = 1'b0;
		miscompares = 0;
		comparisons = 0;
		tick(3);
		sys_rst = 1'b0;
		t_ldo();
		t_run();
		t_half();
		t_sync();
		t_fault();
		t_hic();
		t_rst();
		t_def();
		test_done();
	end
endmodule
`default_nettype wire
